//--- rtl/file_ram.v
// File register memory, 128 x 8, with registered read data
`timescale 1ns/1ps
module file_ram #(
    parameter AW = 7,
    parameter DW = 8
) (
    input  wire          i_clk,
    input  wire [AW-1:0] i_raddr,
    output reg  [DW-1:0] o_rdata,
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [DW-1:0] i_wdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    // Write-first so a read issued beside a write sees new data
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_we && (i_waddr == i_raddr)) begin
            o_rdata <= i_wdata;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

//--- rtl/logic_shift_branch_exec.v
// Execution unit for logic, shift, bit and relative branch operations
`timescale 1ns/1ps
`include "lsb_exec_map.vh"
module logic_shift_branch_exec #(
    parameter AW = 7
) (
    input  wire                i_clk,
    input  wire                i_rstn,
    input  wire                i_start,
    input  wire [`OP_W-1:0]    i_op,
    input  wire [7:0]          i_literal,
    input  wire [8:0]          i_offset,
    input  wire [AW-1:0]       i_faddr,
    input  wire                i_dest,
    input  wire [2:0]          i_bit,
    output reg                 o_busy,
    output reg                 o_done,
    output reg                 o_skip,
    output reg  [7:0]          o_accum,
    output reg                 o_carry,
    output reg                 o_zero,
    output reg  [`PC_W-1:0]    o_pc
);
    // One-hot sequencer states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_READ = 4'h2;
    localparam [3:0] ST_EXEC = 4'h4;
    localparam [3:0] ST_NOP  = 4'h8;

    reg  [3:0]       state_ff;
    reg  [3:0]       nxt_state;
    reg  [`OP_W-1:0] op_ff;
    reg  [7:0]       lit_ff;
    reg  [8:0]       off_ff;
    reg  [AW-1:0]    addr_ff;
    reg              dest_ff;
    reg  [2:0]       bit_ff;
    wire [7:0]       fdata;
    reg              we;
    reg  [7:0]       wdata;
    reg  [7:0]       nxt_accum;
    reg              nxt_carry;
    reg              nxt_zero;
    reg  [`PC_W-1:0] nxt_pc;
    reg              nxt_skip;
    reg              nxt_busy;
    reg              nxt_done;
    reg  [7:0]       bit_mask;
    reg  [7:0]       and_res;
    reg  [7:0]       asr_res;
    wire [`PC_W-1:0] pc_next_instr;
    wire [`PC_W-1:0] off_ext;

    // PC still points at this instruction when the branch resolves; targets start from o_pc + 1
    assign pc_next_instr = o_pc + {{(`PC_W-1){1'b0}}, 1'b1};
    assign off_ext       = {{(`PC_W-9){off_ff[8]}}, off_ff};

    file_ram #(.AW(AW), .DW(8)) u_ram (
        .i_clk   (i_clk),
        .i_raddr (addr_ff),
        .o_rdata (fdata),
        .i_we    (we),
        .i_waddr (addr_ff),
        .i_wdata (wdata)
    );

    // Datapath and sequencing; the read state only fills the RAM pipeline
    always @* begin
        nxt_state = state_ff;
        nxt_accum = o_accum;
        nxt_carry = o_carry;
        nxt_zero  = o_zero;
        nxt_pc    = o_pc;
        nxt_skip  = 1'b0;
        nxt_busy  = o_busy;
        nxt_done  = 1'b0;
        we        = 1'b0;
        wdata     = fdata;
        bit_mask  = 8'h01 << bit_ff;
        and_res   = o_accum & fdata;
        asr_res   = {fdata[`MSB_POS], fdata[`MSB_POS:1]};
        case (state_ff)
            ST_IDLE: begin
                if (i_start) begin
                    nxt_state = ST_READ;
                    nxt_busy  = 1'b1;
                end
            end
            ST_READ: begin
                nxt_state = ST_EXEC;
            end
            ST_EXEC: begin
                nxt_state = ST_IDLE;
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
                nxt_pc    = pc_next_instr;
                case (op_ff)
                    `OP_AND_LITERAL: begin
                        nxt_accum = o_accum & lit_ff;
                        nxt_zero  = ((o_accum & lit_ff) == 8'h00);
                    end
                    `OP_AND_FILE: begin
                        nxt_zero = (and_res == 8'h00);
                        if (dest_ff == `DEST_FILE) begin
                            we    = 1'b1;
                            wdata = and_res;
                        end else begin
                            nxt_accum = and_res;
                        end
                    end
                    `OP_ASR: begin
                        nxt_carry = fdata[0];
                        nxt_zero  = (asr_res == 8'h00);
                        if (dest_ff == `DEST_FILE) begin
                            we    = 1'b1;
                            wdata = asr_res;
                        end else begin
                            nxt_accum = asr_res;
                        end
                    end
                    `OP_BIT_CLEAR: begin
                        we    = 1'b1;
                        wdata = fdata & ~bit_mask;
                    end
                    `OP_BIT_SET: begin
                        we    = 1'b1;
                        wdata = fdata | bit_mask;
                    end
                    `OP_BRANCH_LITERAL: begin
                        nxt_pc    = pc_next_instr + off_ext;
                        nxt_state = ST_NOP;
                        nxt_busy  = 1'b1;
                        nxt_done  = 1'b0;
                    end
                    `OP_BRANCH_ACCUM: begin
                        nxt_pc    = pc_next_instr + {{(`PC_W-8){1'b0}}, o_accum};
                        nxt_state = ST_NOP;
                        nxt_busy  = 1'b1;
                        nxt_done  = 1'b0;
                    end
                    `OP_SKIP_IF_CLEAR: begin
                        if ((fdata & bit_mask) == 8'h00) begin
                            nxt_pc    = pc_next_instr + {{(`PC_W-1){1'b0}}, 1'b1};
                            nxt_skip  = 1'b1;
                            nxt_state = ST_NOP;
                            nxt_busy  = 1'b1;
                            nxt_done  = 1'b0;
                        end
                    end
                    default: begin
                        nxt_state = ST_IDLE;
                    end
                endcase
            end
            ST_NOP: begin
                // Second cycle only retires, holding o_skip
                nxt_state = ST_IDLE;
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
                nxt_skip  = o_skip;
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_busy  = 1'b0;
            end
        endcase
    end

    // Operand capture at start so inputs may change while busy
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            op_ff   <= `OP_AND_LITERAL;
            lit_ff  <= 8'h00;
            off_ff  <= 9'h000;
            addr_ff <= {AW{1'b0}};
            dest_ff <= `DEST_ACCUM;
            bit_ff  <= 3'h0;
        end else if ((state_ff == ST_IDLE) && i_start) begin
            op_ff   <= i_op;
            lit_ff  <= i_literal;
            off_ff  <= i_offset;
            addr_ff <= i_faddr;
            dest_ff <= i_dest;
            bit_ff  <= i_bit;
        end
    end

    // Architectural state and outputs
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= ST_IDLE;
            o_accum  <= `ACCUM_RESET;
            o_carry  <= 1'b0;
            o_zero   <= 1'b0;
            o_pc     <= `PC_RESET;
            o_skip   <= 1'b0;
            o_busy   <= 1'b0;
            o_done   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            o_accum  <= nxt_accum;
            o_carry  <= nxt_carry;
            o_zero   <= nxt_zero;
            o_pc     <= nxt_pc;
            o_skip   <= nxt_skip;
            o_busy   <= nxt_busy;
            o_done   <= nxt_done;
        end
    end
endmodule

//--- rtl/lsb_exec_map.vh
// Opcode codes, field positions, reset values and timing for the execution block
`ifndef LSB_EXEC_MAP_VH
`define LSB_EXEC_MAP_VH
`define OP_W                 3
`define OP_AND_LITERAL       3'h0
`define OP_AND_FILE          3'h1
`define OP_ASR               3'h2
`define OP_BIT_CLEAR         3'h3
`define OP_BIT_SET           3'h4
`define OP_BRANCH_LITERAL    3'h5
`define OP_BRANCH_ACCUM      3'h6
`define OP_SKIP_IF_CLEAR     3'h7
`define DEST_ACCUM           1'h0
`define DEST_FILE            1'h1
`define MSB_POS              7
`define PC_W                 15
`define PC_RESET             15'h0000
`define ACCUM_RESET          8'h00
`define FILE_RESET           8'h00
`define CLK_PERIOD_NS        100
`define CYCLE_NS             100
`define CYCLE_CLKS           ((`CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- verif/logic_shift_branch_exec_test.sv
// Random and corner stimulus with a reference model for the execution unit
`timescale 1ns/1ps
module logic_shift_branch_exec_test;
    reg         clk = 0, rstn = 0, start = 0, dst = 0, m_c = 0, m_z = 0;
    reg  [2:0]  op = 0, bt = 0;
    reg  [7:0]  lit = 0, m_acc = 0;
    reg  [8:0]  off = 0;
    reg  [6:0]  fa = 0;
    reg  [14:0] m_pc = 0;
    reg  [7:0]  mem [0:127];
    reg  [63:0] rw;
    wire        busy, done, skp, c, z;
    wire [7:0]  acc;
    wire [14:0] pc;
    integer     seed = 32'h9374b2fc, n_fail = 0, comparisons = 0, cyc = 0, a, b;
    logic_shift_branch_exec i_logic_shift_branch_exec (.i_clk(clk), .i_rstn(rstn),
        .i_start(start), .i_op(op), .i_literal(lit), .i_offset(off), .i_faddr(fa),
        .i_dest(dst), .i_bit(bt), .o_busy(busy), .o_done(done), .o_skip(skp),
        .o_accum(acc), .o_carry(c), .o_zero(z), .o_pc(pc));
    initial forever #50 clk = ~clk;
    // Hang guard, ops take at most five cycles each
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    task chk(input string nm, input [14:0] e, input [14:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[ERR] %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // Expected program counter after one operation; branches are relative to pc + 1
    function [14:0] exp_pc(input [14:0] p, input [2:0] o, input [8:0] k, input [7:0] w,
                           input t);
        begin
            case (o)
                3'h5: exp_pc = p + 15'h0001 + {{6{k[8]}}, k};
                3'h6: exp_pc = p + 15'h0001 + {7'h00, w};
                default: exp_pc = p + 15'h0001 + {14'h0000, t};
            endcase
        end
    endfunction
    // One operation: drive, model, wait for retire, compare
    task run(input [2:0] o, input [7:0] l, input [8:0] k, input [6:0] f, input d, input [2:0] s);
        reg [7:0] r;
        reg       tk;
        integer   n;
        begin
            @(negedge clk);
            op = o; lit = l; off = k; fa = f; dst = d; bt = s; start = 1;
            r = mem[f];
            tk = 0;
            case (o)
                3'h0: begin m_acc = m_acc & l; m_z = (m_acc == 8'h00); end
                3'h1: begin r = m_acc & r; m_z = (r == 8'h00); end
                3'h2: begin m_c = r[0]; r = {r[7], r[7:1]}; m_z = (r == 8'h00); end
                3'h3: mem[f][s] = 1'b0;
                3'h4: mem[f][s] = 1'b1;
                3'h7: tk = !r[s];
                default: ;
            endcase
            // Destination select only for and-file and shift
            if (o == 3'h1 || o == 3'h2) begin
                if (d) mem[f] = r;
                else m_acc = r;
            end
            m_pc = exp_pc(m_pc, o, k, m_acc, tk);
            @(negedge clk);
            start = 0;
            for (n = 1; n < 9 && done !== 1'b1; n = n + 1) @(negedge clk);
            chk("cycles", (o == 3'h5 || o == 3'h6 || tk) ? 15'h0004 : 15'h0003, n[14:0]);
            chk("accum", m_acc, acc);
            chk("carry", m_c, c);
            chk("zero", m_z, z);
            chk("pc", m_pc, pc);
            chk("skip", tk, skp);
        end
    endtask
    task final_report;
        begin
            if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) rstn = 1;
        // Every bit of every file set or cleared, so later reads are known
        for (a = 0; a < 128; a = a + 1)
            for (b = 0; b < 8; b = b + 1)
                run(($random(seed) & 1) ? 3'h4 : 3'h3, 8'h00, 9'h000,
                    a[6:0], 1'b0, b[2:0]);
        // Mid-run reset clears core state; file contents are not reset
        @(negedge clk) rstn = 0;
        @(negedge clk);
        chk("rst_state", 15'h0000, {busy, done, skp, c, z, acc});
        chk("rst_pc", 15'h0000, pc);
        m_acc = 8'h00;
        m_c = 0;
        m_z = 0;
        m_pc = 15'h0000;
        @(negedge clk) rstn = 1;
        // Offset extremes of the literal branch
        run(3'h5, 8'h00, 9'h100, 7'h00, 1'b0, 3'h0);
        run(3'h5, 8'h00, 9'h0FF, 7'h00, 1'b0, 3'h0);
        // Fields cut from one wide draw so no argument is silently truncated
        for (a = 0; a < 2000; a = a + 1) begin
            rw = {$random(seed), $random(seed)};
            run(rw[2:0], rw[10:3], rw[19:11], rw[26:20], rw[27], rw[30:28]);
        end
        final_report;
    end
endmodule

//--- verif/lsb_exec_sva.sv
// Checker for timing and results at the execution unit ports
`timescale 1ns/1ps
module lsb_exec_sva #(
    parameter AW = 7
) (
    input wire        i_clk,
    input wire        i_rstn,
    input wire        i_start,
    input wire [2:0]  i_op,
    input wire [7:0]  i_literal,
    input wire [8:0]  i_offset,
    input wire        o_busy,
    input wire        o_done,
    input wire        o_skip,
    input wire [7:0]  o_accum,
    input wire        o_carry,
    input wire        o_zero,
    input wire [14:0] o_pc
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Accepted request and sign-extended offset
    wire        take = i_start && !o_busy;
    wire [14:0] off_x = {{6{i_offset[8]}}, i_offset};
    // Branch body: three busy cycles, then retire
    sequence branch_seq;
        (o_busy && !o_done) [*3] ##1 o_done;
    endsequence
    take_busy_a: assert property (take |=> o_busy)
        else $error("busy missing after start");
    single_time_a: assert property (take && i_op < 3'h5 |-> ##3 o_done && !o_skip)
        else $error("single op retire time wrong");
    branch_time_a: assert property (take && (i_op == 3'h5 || i_op == 3'h6) |-> ##1 branch_seq)
        else $error("branch retire time wrong");
    skip_time_a: assert property (take && i_op == 3'h7 |-> ##3 (o_done ^ o_skip))
        else $error("skip timing wrong");
    flag_hold_a: assert property (take && i_op > 3'h2 |=> $stable({o_carry, o_zero, o_accum}) [*3])
        else $error("flags or accum changed");
    carry_hold_a: assert property (take && i_op < 3'h2 |=> $stable(o_carry) [*3])
        else $error("carry changed by and");
    and_lit_a: assert property (take && i_op == 3'h0 |-> ##3 o_accum == ($past(o_accum, 3)
        & $past(i_literal, 3)) && o_zero == (o_accum == 8'h00))
        else $error("and literal result wrong");
    lit_target_a: assert property (take && i_op == 3'h5 |-> ##4 o_pc == $past(o_pc, 4) + 15'h1
        + $past(off_x, 4))
        else $error("literal branch target wrong");
    acc_target_a: assert property (take && i_op == 3'h6 |-> ##4 o_pc == $past(o_pc, 4) + 15'h1
        + $past(o_accum, 4))
        else $error("accum branch target wrong");
    // Retire strobe must never stretch, or back-to-back issue would double count
    done_pulse_a: assert property (o_done |=> !o_done)
        else $error("done held longer than one cycle");
endmodule
bind logic_shift_branch_exec lsb_exec_sva #(.AW(AW)) i_lsb_exec_sva (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_start   (i_start),
    .i_op      (i_op),
    .i_literal (i_literal),
    .i_offset  (i_offset),
    .o_busy    (o_busy),
    .o_done    (o_done),
    .o_skip    (o_skip),
    .o_accum   (o_accum),
    .o_carry   (o_carry),
    .o_zero    (o_zero),
    .o_pc      (o_pc)
);
